//--- hw/ioch_channel.sv
// I/O data channel, cycle-steal buffer and priority interrupt levels
`timescale 1ns/10ps

module ioch_fifo import ioch_pkg::*; #(
    parameter int W = 35,
    parameter int D = FIFO_DEPTH
) (
    input  wire logic         clock,
    input  wire logic         rstn,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0]   cnt_reg;
    wire           push = in_valid && in_ready;
    wire           pop  = out_valid && out_ready;

    assign in_ready  = (cnt_reg != (AW+1)'(D));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem[rd_reg];

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= push ? AW'(wr_reg + 1'b1) : wr_reg;
            rd_reg  <= pop ? AW'(rd_reg + 1'b1) : rd_reg;
            cnt_reg <= (AW+1)'(cnt_reg + push - pop);
        end
    end
endmodule

// Operation
// - Four levels, each with own registers
// - Level changes by program or interrupt
// - Entry point per device, 256 sources
// - Prepare to levels 4-15 is no-op
// - Channel addresses up to 256 devices
// - Direct transfer moves one byte/word
// - Cycle steal series, 65535 bytes maximum
// - Cycle steal overlaps, always ends interrupting
// - Requests polled during ongoing transfers
module ioch_channel import ioch_pkg::*; #(
    parameter int SLOTS = SLOTS_DEF
) (
    input  wire logic              clock,
    input  wire logic              rstn,
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    input  wire ioch_cmd_t         cmd,
    output logic                   done_valid,
    output logic [DATA_W-1:0]      done_data,
    output logic [1:0]             done_cc,
    input  wire logic              prog_lvl_we,
    input  wire logic [LVL_W-1:0]  prog_lvl,
    input  wire logic              prog_exit,
    output logic [LVL_W-1:0]       active_level,
    input  wire logic              reg_we,
    input  wire logic [REG_IDX_W-1:0] reg_idx,
    input  wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0]      reg_rdata,
    output logic                   ent_valid,
    output ioch_ent_t              ent,
    output logic                   stor_valid,
    input  wire logic              stor_ready,
    output ioch_cs_t               stor,
    output logic                   cs_busy,
    output logic                   dio_strobe,
    output logic [DEV_W-1:0]       dio_dev,
    output logic [DATA_W-1:0]      dio_data,
    output logic                   dio_write,
    output logic                   dio_word,
    input  wire logic [SLOTS-1:0]  req_irq,
    input  wire logic [SLOTS-1:0]  req_cs,
    input  wire ioch_pins_t        pins,
    output logic [SLOTS-1:0]       poll_grant,
    output logic                   poll_cs,
    output logic                   poll_reject
);
    logic [2*SLOTS-1:0] req_s1, req_s2;
    ioch_pins_t         pin_s1, pin_s2;
    ioch_poll_t         p_reg;
    ioch_dio_t          d_reg;
    logic [DATA_W-1:0]  regs [LEVELS][REGS_PER_LVL];
    logic               idle_reg, cs_active_reg, cs_pend_reg;
    logic [CNT_W-1:0]   cs_cnt_reg;
    logic [DEV_W-1:0]   cs_dev_reg;
    logic [LVL_W-1:0]   cs_lvl_reg;
    logic               fifo_in_ready;

    function automatic logic [SLOTS-1:0] first_one(input logic [SLOTS-1:0] v);
        first_one = v & (~v + 1'b1);
    endfunction

    // Both request vectors and all device returns arrive asynchronously
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            req_s1 <= '0;
            req_s2 <= '0;
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            req_s1 <= {req_cs, req_irq};
            req_s2 <= req_s1;
            pin_s1 <= pins;
            pin_s2 <= pin_s1;
        end
    end

    wire [SLOTS-1:0] irq_s   = req_s2[SLOTS-1:0];
    wire [SLOTS-1:0] cs_elig = req_s2[2*SLOTS-1:SLOTS] & {SLOTS{cs_active_reg & fifo_in_ready}};
    wire [SLOTS-1:0] pick    = first_one(irq_s | cs_elig);
    wire             pick_cs = |(pick & cs_elig);
    wire             cap     = (p_reg == P_GRANT) && pin_s2.poll_ack;
    wire             acc_ok_irq = idle_reg || (pin_s2.poll_lvl < active_level);
    wire             irq_acc = cap && !poll_cs && acc_ok_irq;
    wire             cs_cap  = cap && poll_cs;
    wire             cs_last = (cs_cnt_reg <= CS_WORD_BYTES);
    wire             cs_end_go = (p_reg == P_IDLE) && cs_pend_reg &&
                                 (idle_reg || (cs_lvl_reg < active_level));
    wire             grant_take = (p_reg == P_IDLE) && (pick != '0) && !cs_end_go;
    wire             take    = cmd_valid && cmd_ready;
    wire             prep_noop = (cmd.op == IOCH_OP_PREPARE) && (cmd.lvl >= PREP_LVL_W'(LEVELS));
    wire             cs_start = take && (cmd.op == IOCH_OP_CSSTART);

    assign cmd_ready = (d_reg == D_IDLE) && !(cmd.op == IOCH_OP_CSSTART &&
                       (cs_active_reg || cs_pend_reg));
    assign cs_busy   = cs_active_reg;

    // Poll handshake runs independently of the direct transfer machine
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            p_reg       <= P_IDLE;
            poll_grant  <= '0;
            poll_cs     <= 1'b0;
            poll_reject <= 1'b0;
        end else begin
            poll_reject <= cap && !poll_cs && !acc_ok_irq;
            unique case (p_reg)
                P_IDLE: if (grant_take) begin
                    p_reg      <= P_GRANT;
                    poll_grant <= pick;
                    poll_cs    <= pick_cs;
                end
                P_GRANT: if (cap) begin
                    p_reg      <= P_REL;
                    poll_grant <= '0;
                end
                P_REL: if (!pin_s2.poll_ack) begin
                    p_reg <= P_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            active_level <= LVL_RESET;
            idle_reg     <= 1'b1;
            ent_valid    <= 1'b0;
            ent          <= '0;
        end else begin
            ent_valid <= irq_acc || cs_end_go;
            if (irq_acc) begin
                active_level <= pin_s2.poll_lvl;
                idle_reg     <= 1'b0;
                ent          <= '{dev: pin_s2.poll_dev, lvl: pin_s2.poll_lvl};
            end else if (cs_end_go) begin
                active_level <= cs_lvl_reg;
                idle_reg     <= 1'b0;
                ent          <= '{dev: cs_dev_reg, lvl: cs_lvl_reg};
            end else if (prog_lvl_we) begin
                active_level <= prog_lvl;
                idle_reg     <= 1'b0;
            end else if (prog_exit) begin
                idle_reg <= 1'b1;
            end
        end
    end

    // Descriptor limit is the counter width itself
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cs_active_reg <= 1'b0;
            cs_pend_reg   <= 1'b0;
            cs_cnt_reg    <= '0;
            cs_dev_reg    <= '0;
            cs_lvl_reg    <= '0;
        end else if (cs_start) begin
            cs_active_reg <= (cmd.count != '0);
            cs_pend_reg   <= (cmd.count == '0);
            cs_cnt_reg    <= cmd.count;
            cs_dev_reg    <= cmd.dev;
            cs_lvl_reg    <= cmd.lvl[LVL_W-1:0];
        end else if (cs_cap) begin
            cs_cnt_reg    <= cs_last ? '0 : CNT_W'(cs_cnt_reg - CS_WORD_BYTES);
            cs_active_reg <= !cs_last;
            cs_pend_reg   <= cs_last;
        end else if (cs_end_go) begin
            cs_pend_reg <= 1'b0;
        end
    end

    // Key and address come from the device as presented
    ioch_fifo #(.W($bits(ioch_cs_t)), .D(FIFO_DEPTH)) u_fifo (
        .clock     (clock),
        .rstn      (rstn),
        .in_valid  (cs_cap),
        .in_ready  (fifo_in_ready),
        .in_data   (pin_s2.poll_cs),
        .out_valid (stor_valid),
        .out_ready (stor_ready),
        .out_data  (stor)
    );

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            d_reg      <= D_IDLE;
            dio_strobe <= 1'b0;
            dio_dev    <= '0;
            dio_data   <= '0;
            dio_write  <= 1'b0;
            dio_word   <= 1'b0;
            done_valid <= 1'b0;
            done_data  <= '0;
            done_cc    <= CC_DONE;
        end else begin
            done_valid <= 1'b0;
            unique case (d_reg)
                D_IDLE: if (take && !cs_start) begin
                    if (cmd.op == IOCH_OP_PREPARE && prep_noop) begin
                        done_valid <= 1'b1;
                        done_cc    <= CC_DONE;
                    end else begin
                        d_reg      <= D_STROBE;
                        dio_strobe <= 1'b1;
                        dio_dev    <= cmd.dev;
                        dio_write  <= (cmd.op != IOCH_OP_READ);
                        dio_word   <= cmd.word;
                        dio_data   <= (cmd.op == IOCH_OP_PREPARE) ?
                                      DATA_W'(cmd.lvl) : cmd.data;
                    end
                end else if (cs_start) begin
                    done_valid <= 1'b1;
                    done_cc    <= CC_DONE;
                end
                D_STROBE: if (pin_s2.dio_ack) begin
                    d_reg      <= D_REL;
                    dio_strobe <= 1'b0;
                    done_data  <= dio_word ? pin_s2.dio_rdata :
                                  {8'h00, pin_s2.dio_rdata[7:0]};
                end
                D_REL: if (!pin_s2.dio_ack) begin
                    d_reg      <= D_IDLE;
                    done_valid <= 1'b1;
                    done_cc    <= CC_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reg_we) begin
            regs[active_level][reg_idx] <= reg_wdata;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= regs[active_level][reg_idx];
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_cs_cap; cs_cap && !cs_last; endsequence
    one_grant_a: assert property ($onehot0(poll_grant))
        else $error("more than one poll grant");
    fixed_order_a: assert property (grant_take |=>
        (poll_grant & $past(irq_s | cs_elig)) != '0 &&
        ($past(irq_s | cs_elig) & (poll_grant - 1'h1)) == '0)
        else $error("grant not lowest requesting slot");
    prep_noop_a: assert property (take && prep_noop |=> done_valid && !dio_strobe)
        else $error("prepare to high level reached device");
    dio_start_a: assert property (take && !prep_noop && !cs_start |=> dio_strobe
        ##1 (dio_strobe || d_reg == D_REL))
        else $error("direct transfer strobe missing");
    cs_count_a: assert property (s_cs_cap |=>
        cs_cnt_reg == CNT_W'($past(cs_cnt_reg) - CS_WORD_BYTES))
        else $error("cycle steal count wrong");
    cs_end_a: assert property (cs_cap && cs_last |=> cs_pend_reg && !cs_active_reg)
        else $error("cycle steal end lost");
    lvl_switch_a: assert property (ent_valid |-> active_level == ent.lvl && !idle_reg)
        else $error("level not switched on entry");
    entry_dev_a: assert property (irq_acc |=> ent_valid && ent.dev == $past(pin_s2.poll_dev))
        else $error("entry device mismatch");
    poll_overlap_a: assert property (d_reg != D_IDLE && p_reg == P_IDLE &&
        (irq_s | cs_elig) != '0 && !cs_end_go |=> poll_grant != '0)
        else $error("poll stalled by direct transfer");
    reg_bank_a: assert property (reg_we ##1 !reg_we && $stable(active_level) &&
        $stable(reg_idx) |=> reg_rdata == $past(reg_wdata, 2))
        else $error("level register write lost");
endmodule

//--- hw/ioch_pkg.sv
// Shared constants and types of the I/O channel and priority level logic
package ioch_pkg;
    localparam int LEVELS       = 4;
    localparam int LVL_W        = 2;
    localparam int PREP_LVL_W   = 4;
    localparam int DEV_W        = 8;
    localparam int DATA_W       = 16;
    localparam int KEY_W        = 3;
    localparam int REGS_PER_LVL = 8;
    localparam int REG_IDX_W    = 3;
    localparam int CNT_W        = 16;
    localparam int SLOTS_DEF    = 8;
    localparam int FIFO_DEPTH   = 16;
    localparam logic [CNT_W-1:0] CS_MAX_BYTES   = 16'hFFFF;
    localparam logic [CNT_W-1:0] CS_WORD_BYTES  = 16'h0002;
    localparam logic [LVL_W-1:0] LVL_RESET      = 2'h3;
    localparam logic [1:0]       CC_DONE        = 2'h0;

    typedef enum logic [1:0] {
        IOCH_OP_READ    = 2'h0,
        IOCH_OP_WRITE   = 2'h1,
        IOCH_OP_CSSTART = 2'h2,
        IOCH_OP_PREPARE = 2'h3
    } ioch_op_t;

    typedef struct packed {
        ioch_op_t              op;
        logic [DEV_W-1:0]      dev;
        logic [DATA_W-1:0]     data;
        logic                  word;
        logic [PREP_LVL_W-1:0] lvl;
        logic [CNT_W-1:0]      count;
    } ioch_cmd_t;

    typedef struct packed {
        logic [KEY_W-1:0]  key;
        logic [DATA_W-1:0] laddr;
        logic [DATA_W-1:0] data;
    } ioch_cs_t;

    typedef struct packed {
        logic [DEV_W-1:0] dev;
        logic [LVL_W-1:0] lvl;
    } ioch_ent_t;

    typedef struct packed {
        logic              dio_ack;
        logic [DATA_W-1:0] dio_rdata;
        logic              poll_ack;
        logic [DEV_W-1:0]  poll_dev;
        logic [LVL_W-1:0]  poll_lvl;
        ioch_cs_t          poll_cs;
    } ioch_pins_t;

    typedef enum logic [1:0] {P_IDLE = 2'b00, P_GRANT = 2'b01, P_REL = 2'b11} ioch_poll_t;
    typedef enum logic [1:0] {D_IDLE = 2'b00, D_STROBE = 2'b01, D_REL = 2'b11} ioch_dio_t;
endpackage

//--- verification/ioch_dev_model.sv
// Behavioural model of the device attachments on the channel
`timescale 1ns/10ps
module ioch_dev_model import ioch_pkg::*; #(
    parameter int SLOTS = SLOTS_DEF
) (
    input  wire logic             clock,
    input  wire logic [LVL_W-1:0] irq_lvl,
    input  wire logic [KEY_W-1:0] data_key,
    input  wire logic [SLOTS-1:0] irq_set,
    input  wire logic [SLOTS-1:0] irq_drop,
    input  wire logic             dio_strobe,
    input  wire logic [DEV_W-1:0] dio_dev,
    input  wire logic [SLOTS-1:0] poll_grant,
    input  wire logic             poll_cs,
    input  wire logic             ent_valid,
    input  wire ioch_ent_t        ent,
    output logic [SLOTS-1:0]      req_irq,
    output ioch_pins_t            pins
);
    logic [DATA_W-1:0] laddr = 16'h1000;
    int                delay = 0;
    logic [DEV_W-1:0]  slot;
    initial pins = '0;
    initial req_irq = '0;
    always_comb begin
        slot = '0;
        for (int i = 0; i < SLOTS; i++) begin
            if (poll_grant[i]) slot = DEV_W'(i);
        end
    end
    always @(posedge clock) begin
        // Odd addresses answer late
        if (dio_strobe && !pins.dio_ack) begin
            delay <= delay + 1;
            if (delay >= (dio_dev[0] ? 3 : 0)) begin
                pins.dio_ack   <= 1'h1;
                pins.dio_rdata <= {8'hC3, dio_dev};
                delay          <= 0;
            end
        end else if (!dio_strobe && pins.dio_ack) begin
            pins.dio_ack   <= 1'h0;
            pins.dio_rdata <= ~pins.dio_rdata;
        end
        if (|poll_grant && !pins.poll_ack) begin
            pins.poll_dev <= 8'h40 | slot;
            pins.poll_lvl <= irq_lvl;
            pins.poll_cs  <= '{data_key, laddr, ~laddr};
            pins.poll_ack <= 1'h1;
            if (poll_cs) laddr <= laddr + 16'h0002;
        end else if (!(|poll_grant) && pins.poll_ack) begin
            // Released device and cycle-steal lines must not keep the old value; the level lines keep theirs
            pins.poll_ack <= 1'h0;
            pins.poll_dev <= ~pins.poll_dev;
            pins.poll_cs  <= ~pins.poll_cs;
        end
        // A refused request keeps standing until it is taken
        req_irq <= (req_irq | irq_set) & ~irq_drop;
        if (ent_valid) req_irq[ent.dev[2:0]] <= 1'h0;
    end
endmodule

//--- verification/tb_ioch_channel.sv
// Self-checking bench of the I/O channel and interrupt levels
`timescale 1ns/10ps
module tb_ioch_channel import ioch_pkg::*;;
    logic clock = 1'h0, rstn = 1'h0, cmd_valid = 1'h0, prog_lvl_we = 1'h0, prog_exit = 1'h0;
    logic reg_we = 1'h0, stor_ready = 1'h0;
    logic cmd_ready, done_valid, ent_valid, stor_valid, cs_busy, dio_strobe, dio_write;
    logic dio_word, poll_cs, poll_reject;
    ioch_cmd_t         cmd = '0;
    logic [LVL_W-1:0]  prog_lvl = '0, irq_lvl = '0, active_level;
    logic [2:0]        reg_idx = '0;
    logic [15:0]       reg_wdata = '0, reg_rdata, done_data, dio_data;
    logic [1:0]        done_cc;
    logic [7:0]        req_cs = '0, irq_set = '0, irq_drop = '0, req_irq, poll_grant, dio_dev;
    ioch_ent_t         ent, last_ent;
    ioch_cs_t          stor;
    ioch_pins_t        pins;
    ioch_cs_t          words[$];
    logic [25:0]       last_dio;
    int n_mismatch = 0, cmp_count = 0, n_ent = 0, n_rej = 0, n_strb = 0, n_ovl = 0;

    always #5 clock = ~clock;

    ioch_channel u_ioch_channel (.clock(clock), .rstn(rstn), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd(cmd), .done_valid(done_valid), .done_data(done_data),
        .done_cc(done_cc), .prog_lvl_we(prog_lvl_we), .prog_lvl(prog_lvl),
        .prog_exit(prog_exit), .active_level(active_level), .reg_we(reg_we),
        .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .ent_valid(ent_valid), .ent(ent), .stor_valid(stor_valid), .stor_ready(stor_ready),
        .stor(stor), .cs_busy(cs_busy), .dio_strobe(dio_strobe), .dio_dev(dio_dev),
        .dio_data(dio_data), .dio_write(dio_write), .dio_word(dio_word), .req_irq(req_irq),
        .req_cs(req_cs), .pins(pins), .poll_grant(poll_grant), .poll_cs(poll_cs),
        .poll_reject(poll_reject));
    ioch_dev_model u_ioch_dev_model (.clock(clock), .irq_lvl(irq_lvl), .data_key(3'h5),
        .irq_set(irq_set), .irq_drop(irq_drop), .dio_strobe(dio_strobe), .dio_dev(dio_dev),
        .poll_grant(poll_grant), .poll_cs(poll_cs), .ent_valid(ent_valid), .ent(ent),
        .req_irq(req_irq), .pins(pins));

    always @(posedge clock) begin
        if (ent_valid) n_ent++;
        if (ent_valid) last_ent = ent;
        if (poll_reject) n_rej++;
        if (stor_valid && stor_ready) words.push_back(stor);
        if ($rose(dio_strobe)) n_strb++;
        if ($rose(dio_strobe)) last_dio = {dio_write, dio_word, dio_dev, dio_data};
        if (dio_strobe && |poll_grant) n_ovl++;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic send(input ioch_op_t op, input logic [7:0] dev, input logic word,
                        input logic [3:0] lvl, input logic [15:0] count);
        cmd = '{op, dev, 16'h5AA5, word, lvl, count};
        cmd_valid = 1'h1;
        while (cmd_ready !== 1'h1) tick(1);
        tick(1);
        cmd_valid = 1'h0;
    endtask
    task automatic wait_done();
        for (int i = 0; i < 300 && done_valid !== 1'h1; i++) tick(1);
        chk("done_valid", 1, done_valid);
        chk("done_cc", CC_DONE, done_cc);
    endtask
    task automatic wait_ent(input int n);
        for (int i = 0; i < 900 && n_ent < n; i++) tick(1);
        chk("entries", n, n_ent);
    endtask
    task automatic set_lvl(input logic ex, input logic [1:0] l);
        prog_lvl = l;
        prog_lvl_we = !ex;
        prog_exit = ex;
        tick(1);
        prog_lvl_we = 1'h0;
        prog_exit = 1'h0;
        tick(1);
    endtask

    task automatic t_dio();
        logic [7:0] devs[3] = '{8'hFF, 8'h00, 8'h81};
        int k;
        foreach (devs[d]) for (int w = 0; w < 2; w++) begin
            k = n_strb;
            send(IOCH_OP_READ, devs[d], w[0], 4'h0, 16'h0000);
            wait_done();
            chk("rdata", w ? {8'hC3, devs[d]} : {8'h00, devs[d]}, done_data);
            chk("strobes", 1, n_strb - k);
            chk("dev", devs[d], last_dio[23:16]);
        end
        send(IOCH_OP_WRITE, 8'h10, 1'h1, 4'h0, 16'h0000);
        wait_done();
        chk("write", {2'h3, 8'h10, 16'h5AA5}, last_dio);
    endtask
    task automatic t_prep();
        int k;
        for (int l = 4; l < 16; l++) begin
            k = n_strb;
            send(IOCH_OP_PREPARE, 8'h22, 1'h0, l[3:0], 16'h0000);
            wait_done();
            chk("prep strobes", 0, n_strb - k);
            tick(1);
        end
        send(IOCH_OP_PREPARE, 8'h22, 1'h0, 4'h2, 16'h0000);
        wait_done();
        chk("prep", {1'h1, 8'h22, 2'h2}, {last_dio[25], last_dio[23:16], last_dio[1:0]});
    endtask
    task automatic t_regs();
        for (int l = 0; l < 4; l++) begin
            set_lvl(1'h0, l[1:0]);
            reg_idx = 3'h5;
            reg_wdata = 16'hA0 + l[15:0];
            reg_we = 1'h1;
            tick(1);
            reg_we = 1'h0;
        end
        for (int l = 3; l >= 0; l--) begin
            set_lvl(1'h0, l[1:0]);
            tick(2);
            chk("level reg", 16'hA0 + l[15:0], reg_rdata);
            chk("level", l, active_level);
        end
    endtask
    task automatic t_irq();
        int n0 = n_ent, r0 = n_rej;
        set_lvl(1'h1, 2'h0);
        irq_lvl = 2'h1;
        irq_set = 8'h24;
        tick(1);
        irq_set = 8'h00;
        wait_ent(n0 + 1);
        chk("first entry", {8'h42, 2'h1}, last_ent);
        chk("level", 1, active_level);
        for (int i = 0; i < 600 && n_rej == r0; i++) tick(1);
        chk("refused", 1, n_rej != r0);
        chk("no entry", n0 + 1, n_ent);
        irq_lvl = 2'h0;
        wait_ent(n0 + 2);
        chk("second entry", {8'h45, 2'h0}, last_ent);
        chk("level", 0, active_level);
    endtask
    task automatic t_cs();
        int n0;
        int o0;
        set_lvl(1'h1, 2'h0);
        n0 = n_ent;
        req_cs = 8'h08;
        send(IOCH_OP_CSSTART, 8'h03, 1'h1, 4'h2, 16'h0028);
        wait_done();
        tick(2);
        chk("busy", 1, cs_busy);
        o0 = n_ovl;
        send(IOCH_OP_READ, 8'h81, 1'h1, 4'h0, 16'h0000);
        wait_done();
        chk("overlap", 1, cs_busy);
        chk("polled in transfer", 1, n_ovl != o0);
        cmd.op = IOCH_OP_CSSTART;
        cmd_valid = 1'h1;
        tick(1);
        chk("second series", 0, cmd_ready);
        cmd_valid = 1'h0;
        // Stalled storage: buffer fills and the poller must hold off
        tick(300);
        chk("stalled", 0, words.size());
        stor_ready = 1'h1;
        wait_ent(n0 + 1);
        tick(40);
        req_cs = 8'h00;
        chk("words", 20, words.size());
        foreach (words[i]) chk("cs word", {3'h5, 16'h1000 + 16'(2 * i)}, words[i][34:16]);
        foreach (words[i]) chk("cs data", 16'(~(16'h1000 + 16'(2 * i))), words[i][15:0]);
        chk("series end", {8'h03, 2'h2}, last_ent);
        chk("idle", 0, cs_busy);
        send(IOCH_OP_CSSTART, 8'h07, 1'h1, 4'h0, 16'h0000);
        wait_done();
        wait_ent(n0 + 2);
        chk("empty series", {8'h07, 2'h0}, last_ent);
        chk("no words", 20, words.size());
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #300000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        tick(4);
        rstn = 1'h1;
        chk("reset level", LVL_RESET, active_level);
        chk("reset ready", 1, cmd_ready);
        t_dio();
        t_prep();
        t_regs();
        t_irq();
        t_cs();
        tally_and_finish();
    end
endmodule
